// >>> src/lsd_consts.vh
`ifndef LSD_CONSTS_VH
`define LSD_CONSTS_VH
// array geometry
`define LSD_PIXELS        8'd128
`define LSD_FRAME_CLKS    8'd129
`define LSD_RECHARGE_CLKS 8'd18
`define LSD_PIX_W         8
`define LSD_CNT_W         8
// output fifo shape
`define LSD_FIFO_DEPTH    8
`define LSD_FIFO_AW       3
`endif

// >>> src/lsd_fifo.v
`timescale 1ns/1ps
`default_nettype none
// small synchronous fifo with valid/ready on both sides
module lsd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstn,
    input  wire             ce,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1]; // storage
    reg  [AW-1:0]    wr_ptr;          // write index
    reg  [AW-1:0]    rd_ptr;          // read index
    reg  [AW:0]      count;           // occupancy
    wire             push;
    wire             pop;

    // full when the top count bit is set; depth is a power of two
    assign in_ready  = ~count[AW];
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    // storage write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and count
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // lsd_fifo
`default_nettype wire

// >>> src/lsd_sensor.v
`timescale 1ns/1ps
`default_nettype none
`include "lsd_consts.vh"
module lsd_sensor (
    // clock and reset
    input  wire                  clk,
    input  wire                  rstn,
    input  wire                  ce,
    // sensor pins from controller
    input  wire                  sensor_clock,
    input  wire                  start_pulse,
    // light level per pixel, sampled at integration end
    input  wire [`LSD_PIX_W-1:0] light_level,
    // serial pixel output
    output reg  [`LSD_PIX_W-1:0] pixel_analog_out,
    output reg                   pixel_strobe,
    // buffered pixel stream
    output wire                  pix_valid,
    input  wire                  pix_ready,
    output wire [`LSD_PIX_W-1:0] pix_data,
    // status
    output reg                   readout_busy,
    output reg                   integrating,
    output reg                   overrun,
    output wire                  stream_stall
);
    ////////////////////////////////////////////////////////////////
    // states
    // one-hot codes; any other code falls back to idle via default
    localparam [2:0] ST_IDLE  = 3'b001; // integrating, no frame
    localparam [2:0] ST_ARMED = 3'b010; // start seen, awaiting clock
    localparam [2:0] ST_SHIFT = 3'b100; // shifting pixels out

    // increment helper, used only by the frame counter clk_cnt
    // wraps at 8 bits; the frame counter never passes 129
    function [`LSD_CNT_W-1:0] inc8;
        input [`LSD_CNT_W-1:0] v;
        begin
            inc8 = v + 8'h01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    // both pins come from the controller's own clock domain, so each
    // passes two flops before any logic looks at it; the edge detect
    // then reads only the second stage, never the first
    // both detectors idle low after reset, matching the idle pin level,
    // so a released reset never fakes a clock or start edge
    reg  [1:0] ck_sync;             // clock pin two-stage
    reg  [1:0] si_sync;             // start pin two-stage
    reg        ck_last;             // previous synced clock
    reg        si_last;             // previous synced start
    wire       ck_rise;
    wire       si_rise;
    assign ck_rise = ck_sync[1] & ~ck_last;
    assign si_rise = si_sync[1] & ~si_last;

    // sample pins
    // ce low freezes both stages, like every other register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_sync <= 2'b00;
            si_sync <= 2'b00;
            ck_last <= 1'b0;
            si_last <= 1'b0;
        end else if (ce) begin
            ck_sync <= {ck_sync[0], sensor_clock};
            si_sync <= {si_sync[0], start_pulse};
            ck_last <= ck_sync[1];
            si_last <= si_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////
    // pixel array and frame control
    // the array holds one frame; the counter runs from the start edge
    reg  [`LSD_PIX_W-1:0] pix_mem [0:127]; // held charges
    reg  [2:0]            state;           // frame state
    reg  [`LSD_CNT_W-1:0] clk_cnt;         // clocks since start
    reg  [6:0]            wr_idx;          // charge capture index
    reg                   fifo_push;       // one pixel to stream
    wire                  fifo_in_ready;

    // buffer full: the next strobed pixel is lost
    assign stream_stall = ~fifo_in_ready;

    // charge accumulation: latest light of each pixel, round robin
    // the store is frozen while a frame is shifting out, so the values
    // released are those captured at the start edge, even after the
    // recharge point has passed in the middle of the frame
    // no reset: contents are don't-care until the first integration
    always @(posedge clk) begin
        if (ce && integrating && !readout_busy) begin
            // only idle integration writes the array
            pix_mem[wr_idx] <= light_level;
        end
    end

    // frame sequencer
    // start edge: freeze charges, raise busy, wait for the first clock
    // clock rise k (1..128): present pixel k-1 with a one-cycle strobe
    // clock rise 18: integration restarts for the next frame
    // clock rise 129: output returns to zero and the frame ends
    // a start edge inside a frame is refused and only sets overrun;
    // the controller must space its start pulses a full frame apart
    // every step acts on the synced pin edge, some three cycles late
    // limitation: if no clock follows a start, the block stays armed
    // until the next reset, since the controller owns the clock
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state            <= ST_IDLE;
            clk_cnt          <= 8'h00;
            wr_idx           <= 7'h00;
            pixel_analog_out <= 8'h00;
            pixel_strobe     <= 1'b0;
            readout_busy     <= 1'b0;
            integrating      <= 1'b1;
            overrun          <= 1'b0;
            fifo_push        <= 1'b0;
        end else if (ce) begin
            pixel_strobe <= 1'b0;
            fifo_push    <= 1'b0;
            // write index sweeps the array while charges build
            if (integrating) begin
                wr_idx <= wr_idx + 7'h01;
            end
            case (state)
                ST_IDLE: begin
                    // start freezes charges and arms the shift
                    // the counter restarts here, so every frame counts from zero
                    if (si_rise) begin
                        state        <= ST_ARMED;
                        clk_cnt      <= 8'h00;
                        readout_busy <= 1'b1;
                        integrating  <= 1'b0;
                    end
                end
                ST_ARMED: begin
                    // a second start before the first clock is refused too
                    if (si_rise) begin
                        overrun <= 1'b1;
                    end
                    // first clock edge drives pixel zero
                    if (ck_rise) begin
                        state            <= ST_SHIFT;
                        clk_cnt          <= 8'h01;
                        pixel_analog_out <= pix_mem[0];
                        pixel_strobe     <= 1'b1;
                        fifo_push        <= 1'b1;
                    end
                end
                ST_SHIFT: begin
                    // early start only sets overrun; the frame carries on
                    if (si_rise) begin
                        overrun <= 1'b1;
                    end
                    if (ck_rise) begin
                        clk_cnt <= inc8(clk_cnt);
                        if (inc8(clk_cnt) == `LSD_RECHARGE_CLKS) begin
                            integrating <= 1'b1;
                        end
                        if (clk_cnt < `LSD_PIXELS) begin
                            // one pixel per clock period
                            pixel_analog_out <= pix_mem[clk_cnt[6:0]];
                            pixel_strobe     <= 1'b1;
                            fifo_push        <= 1'b1;
                        end else begin
                            // clock 129 carries no pixel: output rests
                            // at zero and no strobe is raised
                            pixel_analog_out <= 8'h00;
                        end
                        // 129th rise closes the frame and frees the start input
                        if (inc8(clk_cnt) == `LSD_FRAME_CLKS) begin
                            state        <= ST_IDLE;
                            readout_busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // pixel stream buffer
    // the sensor cannot be paused mid-frame, so a full buffer drops the
    // pixel offered to it; stream_stall shows when that happens and a
    // consumer that keeps pix_ready high never loses a pixel at any
    // legal clock rate, since a pixel arrives at most every few cycles
    // the buffer shares ce, so a frozen block neither fills nor drains
    lsd_fifo #(
        .WIDTH (`LSD_PIX_W),
        .DEPTH (`LSD_FIFO_DEPTH),
        .AW    (`LSD_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (pixel_analog_out),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix_data)
    );
endmodule // lsd_sensor
`default_nettype wire

// >>> test/lsd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lsd_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins and status
    input wire logic sensor_clock,
    input wire logic start_pulse,
    input wire logic pixel_strobe,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic readout_busy,
    input wire logic integrating,
    input wire logic overrun,
    input wire logic stream_stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] n_ck; // clock rises this frame
    logic [7:0] n_px; // strobes this frame
    sequence fresh; $rose(start_pulse) && !readout_busy; endsequence
    sequence late; $rose(start_pulse) && readout_busy; endsequence
    ////////////////////////////////////////
    // frame counters, cleared by an accepted start
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            n_ck <= 8'h00;
            n_px <= 8'h00;
        end else if ($rose(start_pulse) && !readout_busy) begin
            n_ck <= 8'h00;
            n_px <= 8'h00;
        end else begin
            n_ck <= n_ck + {7'h00, $rose(sensor_clock)};
            n_px <= n_px + {7'h00, pixel_strobe};
        end
    end
    a_busy_on_start: assert property (fresh |-> ##[1:4] readout_busy) else $error("busy late");
    a_charge_stops: assert property (fresh |-> ##[1:4] !integrating) else $error("charge on");
    a_charge_at_18: assert property ($rose(integrating) |-> n_ck == 8'h12) else $error("recharge");
    a_frame_length: assert property ($fell(readout_busy) |-> n_ck == 8'h81) else $error("length");
    a_pixel_count: assert property ($fell(readout_busy) |-> n_px == 8'h80) else $error("pixels");
    a_strobe_single: assert property (pixel_strobe |=> !pixel_strobe) else $error("strobe");
    a_overrun_set: assert property (late |-> ##[1:5] overrun) else $error("overrun");
    a_overrun_hold: assert property (overrun |=> overrun) else $error("sticky");
    a_stall_full: assert property (stream_stall |-> pix_valid) else $error("stall");
    a_stall_holds: assert property (stream_stall && !pix_ready |=> stream_stall) else $error("full lost");
endmodule // lsd_chk
bind lsd_sensor lsd_chk u_chk (.*);
`default_nettype wire

// >>> test/lsd_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: start and gated clock
module lsd_ctl_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       extra,
    input  wire logic [2:0] half,
    input  wire logic [7:0] wait_cnt,
    output logic            sensor_clock,
    output logic            start_pulse,
    output logic            done
);
    int k;
    initial begin
        sensor_clock = 0;
        start_pulse = 0;
        done = 1;
    end
    // one clk stands for a prescaled tick
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one frame per request
    always begin
        @(posedge clk);
        if (go) begin
            #1 done = 0;
            start_pulse = 1;
            step(half);
            sensor_clock = 1;
            step(half);
            start_pulse = 0;
            step(half);
            sensor_clock = 0;
            for (k = 1; k < 129; k++) begin
                step(half);
                start_pulse = extra && k == 64;
                step(half);
                sensor_clock = 1;
                step(2 * half);
                sensor_clock = 0;
                start_pulse = 0;
            end
            step(wait_cnt);
            done = 1;
        end
    end
endmodule // lsd_ctl_model
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rstn = 0, go = 0, extra = 0, pix_ready = 0, ce = 1;
    logic [2:0] half = 3'h2;
    logic [7:0] wait_cnt = 8'h10, light_level = 8'h00;
    logic [1:0] mode = 2'h0; // ready: low, random, high
    wire logic sck, spl, done, strobe, pix_valid, busy, integ, overrun, stall;
    wire logic [7:0] pix_out, pix_data;
    logic [7:0] q[$];
    int err_total = 0, n_tests = 0, n_str = 0, n_pop = 0, i;
    always #12.5 clk = ~clk;
    lsd_ctl_model u_ctl (.clk(clk), .go(go), .extra(extra), .half(half), .wait_cnt(wait_cnt),
        .sensor_clock(sck), .start_pulse(spl), .done(done));
    lsd_sensor dut (.clk(clk), .rstn(rstn), .ce(ce), .sensor_clock(sck), .start_pulse(spl),
        .light_level(light_level), .pixel_analog_out(pix_out), .pixel_strobe(strobe), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data), .readout_busy(busy), .integrating(integ),
        .overrun(overrun), .stream_stall(stall));
    task chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    function int exp_pops(input bit stalled); // fifo depth when stalled
        return stalled ? 8 : 128;
    endfunction
    // strobed pixels must leave the fifo in order
    always @(posedge clk) begin
        if (strobe === 1'b1 && ce === 1'b1) begin
            n_str++;
            // a pixel offered to a full buffer is dropped by design
            if (stall === 1'b0) q.push_back(pix_out);
        end
        if (pix_valid === 1'b1 && pix_ready === 1'b1 && ce === 1'b1) begin
            n_pop++;
            chk(q.size() > 0 && pix_data === q.pop_front(), "data");
        end
        #1 light_level = $urandom;
        pix_ready = mode == 2'h2 || (mode == 2'h1 && $urandom % 2);
    end
    task frame(input bit bad);
        extra = bad;
        go = 1;
        wait (done === 1'b0);
        @(posedge clk);
        #1 go = 0;
        wait (done === 1'b1);
    endtask
    task drain(input bit stalled);
        mode = 2'h2;
        repeat (20) @(posedge clk);
        #1 mode = 2'h0;
        chk(n_pop == exp_pops(stalled) && n_str == 128 && pix_valid === 1'b0, "drain");
        q.delete();
        n_pop = 0;
        n_str = 0;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #1000000 err_total++;
        summarize;
    end
    initial begin
        void'($urandom(47));
        repeat (2) @(posedge clk);
        #1 rstn = 1;
        chk(integ === 1'b1 && busy === 1'b0 && pix_valid === 1'b0 && overrun === 1'b0, "reset");
        frame(0);
        chk(stall === 1'b1 && integ === 1'b1 && busy === 1'b0, "full");
        ce = 0; // frozen block must not drain to a ready consumer
        mode = 2'h2;
        repeat (10) @(posedge clk);
        chk(n_pop == 0 && stall === 1'b1 && pix_valid === 1'b1, "freeze");
        #1 ce = 1;
        drain(1);
        for (i = 0; i < 3; i++) begin
            mode = 2'h1;
            wait_cnt = $urandom;
            frame(i == 2);
            drain(0);
        end
        chk(overrun === 1'b1, "late start");
        fork frame(0); join_none
        repeat (300) @(posedge clk);
        #1 rstn = 0;
        q.delete();
        @(posedge clk);
        #1 rstn = 1;
        chk(overrun === 1'b0 && busy === 1'b0, "rerun");
        wait fork;
        n_str = 0;
        n_pop = 0;
        frame(0);
        drain(1);
        summarize;
    end
endmodule // testbench
`default_nettype wire
